// file: verilog/eci_target.sv
// Two-wire target interface plus 24-bit event counter.
// Assumes scl, sda, count input and clear pin are asynchronous pins.
`timescale 1ns/100ps
`include "eci_params.svh"
// Functional notes
// - First byte after start is address 0110010 plus direction; answer only it.
// - Direction 0 writes scratch; direction 1 reads count or scratch.
// - Target acknowledges each byte received during a write.
// - All bytes travel most significant bit first.
// - Start instead of stop is a repeated start; new address accepted.
// - Count input edges ignored from start to stop; clear pin or command can still zero counter.
// - Plain read returns 24-bit count in bytes two to four, MSB first.
// - Reads beyond three register bytes return all ones.
// - Scratch stores bits from third byte bit 7 to fifth byte bit 3.
// - Fifth byte low bits 0,1,0 clear counter; others only update scratch.
// - Scratch read is dummy write pointer zero, repeated start, read.
// - Stop resets pointer so a later read returns count.
// - Clear pin never resets the serial interface.
// - No start or stop recognised while target drives data low.
// - Counter is 24-bit, increments on count rising edge, wraps.
// - Add one count if input low at start and high at stop.
// - Wrap output toggles on wrap; cleared by pin or command.
module eci_target
   import eci_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Two-wire bus
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   // Counter pins
   input wire logic i_count_in,
   input wire logic i_clear_n,
   output logic o_wrap,
   // Register views
   output logic [`ECI_CNT_WIDTH-1:0] o_count_value_bits,
   output logic [`ECI_SCRATCH_WIDTH-1:0] o_scratch_bits,
   output logic [2:0] o_counter_clear_command_bits
);
   import eci_pkg::*;
   logic rst_m_q, rstn_q;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_m_q <= 1'b0;
         rstn_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rstn_q <= rst_m_q;
      end
   end

   logic scl_s, sda_s, cin_s, clr_s;
   eci_sync u_scl (.i_clk(i_clk), .i_rstn(rstn_q), .i_async(i_scl),
      .o_sync(scl_s));
   eci_sync u_sda (.i_clk(i_clk), .i_rstn(rstn_q), .i_async(i_sda),
      .o_sync(sda_s));
   eci_sync u_cin (.i_clk(i_clk), .i_rstn(rstn_q), .i_async(i_count_in),
      .o_sync(cin_s));
   eci_sync u_clr (.i_clk(i_clk), .i_rstn(rstn_q), .i_async(i_clear_n),
      .o_sync(clr_s));

   logic scl_q, sda_q, cin_q;
   always_ff @(posedge i_clk or negedge rstn_q) begin
      if (!rstn_q) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         cin_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         cin_q <= cin_s;
      end
   end
   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   // Own drive blocks start and stop detection
   wire start_det = scl_s & scl_q & sda_q & ~sda_s & ~o_sda_oe;
   wire stop_det = scl_s & scl_q & ~sda_q & sda_s & ~o_sda_oe;
   wire cin_rise = cin_s & ~cin_q;

   // Serial engine state
   eci_state_type st_q, st_d;
   logic [7:0] sh_q, sh_d;
   logic [3:0] bit_q, bit_d;
   logic [2:0] byte_q, byte_d;
   logic dir_q, dir_d;
   logic ptr_q, ptr_d;
   logic busy_q, busy_d;
   logic cin_at_start_q, cin_at_start_d;
   logic oe_q, oe_d;
   logic [`ECI_SCRATCH_WIDTH-1:0] scr_q, scr_d;
   logic [2:0] cmd_q, cmd_d;
   logic [15:0] wbuf_q, wbuf_d;
   logic clr_cmd;
   logic stop_bump;

   function automatic logic [7:0] read_byte(input logic [2:0] idx,
      input logic sel_scr, input logic [23:0] cnt,
      input logic [23:0] scr);
      logic [23:0] src;
      src = sel_scr ? scr : cnt;
      case (idx)
         3'h0: read_byte = src[23:16];
         3'h1: read_byte = src[15:8];
         3'h2: read_byte = src[7:0];
         default: read_byte = `ECI_IDLE_BYTE;
      endcase
   endfunction

   logic [23:0] cnt_q, cnt_d;
   logic wrap_q, wrap_d;

   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      bit_d = bit_q;
      byte_d = byte_q;
      dir_d = dir_q;
      ptr_d = ptr_q;
      busy_d = busy_q;
      cin_at_start_d = cin_at_start_q;
      oe_d = oe_q;
      scr_d = scr_q;
      cmd_d = cmd_q;
      wbuf_d = wbuf_q;
      clr_cmd = 1'b0;
      stop_bump = 1'b0;
      if (start_det) begin
         // Repeated start keeps pointer and busy
         if (!busy_q) begin
            cin_at_start_d = cin_s;
         end
         busy_d = 1'b1;
         st_d = ST_ADDR;
         bit_d = 4'h0;
         byte_d = 3'h0;
         oe_d = 1'b0;
      end else if (stop_det) begin
         // Only stop clears busy; it returns to idle and sets pointer back to count
         stop_bump = busy_q & ~cin_at_start_q & cin_s;
         busy_d = 1'b0;
         ptr_d = 1'b1;
         st_d = ST_IDLE;
         oe_d = 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               oe_d = 1'b0;
            end
            ST_ADDR, ST_WRITE: begin
               if (scl_rise) begin
                  sh_d = {sh_q[6:0], sda_s};
                  bit_d = bit_q + 4'h1;
               end
               if (scl_fall && bit_q == 4'h8) begin
                  bit_d = 4'h0;
                  if (st_q == ST_ADDR) begin
                     if (sh_q[7:1] == `ECI_TARGET_ADDR) begin
                        dir_d = sh_q[0];
                        oe_d = 1'b1;
                        st_d = ST_WACK;
                     end else begin
                        st_d = ST_IDLE;
                     end
                  end else begin
                     oe_d = 1'b1;
                     st_d = ST_WACK;
                     case (byte_q)
                        3'h0: ptr_d = sh_q[`ECI_PTR_BIT];
                        3'h1: wbuf_d[15:8] = sh_q;
                        3'h2: wbuf_d[7:0] = sh_q;
                        3'h3: begin
                           scr_d = {wbuf_q, sh_q[7:3]};
                           cmd_d = sh_q[2:0];
                           clr_cmd = sh_q[2:0] == `ECI_CLEAR_PATTERN;
                        end
                        default: ;
                     endcase
                     if (byte_q != 3'h7) begin
                        byte_d = byte_q + 3'h1;
                     end
                  end
               end
            end
            ST_WACK: begin
               if (scl_fall) begin
                  if (dir_q) begin
                     sh_d = read_byte(3'h0, ~ptr_q, cnt_q,
                        {scr_q, cmd_q});
                     byte_d = 3'h1;
                     oe_d = ~sh_d[7];
                     st_d = ST_READ;
                  end else begin
                     oe_d = 1'b0;
                     st_d = ST_WRITE;
                  end
               end
            end
            ST_READ: begin
               if (scl_fall) begin
                  bit_d = bit_q + 4'h1;
                  if (bit_q == 4'h7) begin
                     oe_d = 1'b0;
                     st_d = ST_RACK;
                  end else begin
                     sh_d = {sh_q[6:0], 1'b1};
                     oe_d = ~sh_q[6];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  // Missing ack ends our drive
                  if (sda_s) begin
                     st_d = ST_IDLE;
                  end
               end else if (scl_fall) begin
                  bit_d = 4'h0;
                  sh_d = read_byte(byte_q, ~ptr_q, cnt_q, {scr_q, cmd_q});
                  if (byte_q != 3'h7) begin
                     byte_d = byte_q + 3'h1;
                  end
                  oe_d = ~sh_d[7];
                  st_d = ST_READ;
               end
            end
            default: st_d = ST_IDLE;
         endcase
      end
   end

   // Counter: frozen while busy, clear pin or command zero it
   always_comb begin
      cnt_d = cnt_q;
      wrap_d = wrap_q;
      if (!clr_s || clr_cmd) begin
         cnt_d = '0;
         wrap_d = 1'b0;
      end else if ((cin_rise && !busy_q) || stop_bump) begin
         cnt_d = cnt_q + 24'h000001;
         if (cnt_q == 24'hFFFFFF) begin
            wrap_d = ~wrap_q;
         end
      end
   end

   always_ff @(posedge i_clk or negedge rstn_q) begin
      if (!rstn_q) begin
         st_q <= ST_IDLE;
         sh_q <= 8'h00;
         bit_q <= 4'h0;
         byte_q <= 3'h0;
         dir_q <= 1'b0;
         ptr_q <= 1'b1;
         busy_q <= 1'b0;
         cin_at_start_q <= 1'b1;
         oe_q <= 1'b0;
         scr_q <= `ECI_SCRATCH_RESET;
         cmd_q <= `ECI_CMD_RESET;
         wbuf_q <= 16'h0000;
         cnt_q <= 24'h000000;
         wrap_q <= 1'b0;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         bit_q <= bit_d;
         byte_q <= byte_d;
         dir_q <= dir_d;
         ptr_q <= ptr_d;
         busy_q <= busy_d;
         cin_at_start_q <= cin_at_start_d;
         oe_q <= oe_d;
         scr_q <= scr_d;
         cmd_q <= cmd_d;
         wbuf_q <= wbuf_d;
         cnt_q <= cnt_d;
         wrap_q <= wrap_d;
      end
   end

   assign o_sda = 1'b0;
   assign o_sda_oe = oe_q;
   assign o_wrap = wrap_q;
   assign o_count_value_bits = cnt_q;
   assign o_scratch_bits = scr_q;
   assign o_counter_clear_command_bits = cmd_q;

   // Checks
   property p_busy_freeze;
      @(posedge i_clk) disable iff (!rstn_q)
         (busy_q && !stop_bump && clr_s && !clr_cmd) |=> $stable(cnt_q);
   endproperty
   a_busy_freeze: assert property (p_busy_freeze)
      else $error("Counter moved during transfer");
   property p_ack_addr;
      @(posedge i_clk) disable iff (!rstn_q)
         (st_q == ST_ADDR && st_d == ST_WACK) |=> oe_q;
   endproperty
   a_ack_addr: assert property (p_ack_addr)
      else $error("Address not acknowledged");
   property p_nomatch;
      @(posedge i_clk) disable iff (!rstn_q)
         (st_q == ST_ADDR && scl_fall && bit_q == 4'h8 &&
          sh_q[7:1] != `ECI_TARGET_ADDR) |=> !oe_q;
   endproperty
   a_nomatch: assert property (p_nomatch)
      else $error("Drove bus for foreign address");
   property p_wack;
      @(posedge i_clk) disable iff (!rstn_q)
         (st_q == ST_WRITE && st_d == ST_WACK) |=> oe_q;
   endproperty
   a_wack: assert property (p_wack)
      else $error("Write byte not acknowledged");
   property p_clear;
      @(posedge i_clk) disable iff (!rstn_q)
         clr_cmd |=> (cnt_q == 24'h000000 && !wrap_q);
   endproperty
   a_clear: assert property (p_clear)
      else $error("Clear command ignored");
   property p_stop_ptr;
      @(posedge i_clk) disable iff (!rstn_q)
         stop_det |=> (ptr_q && !busy_q && st_q == ST_IDLE);
   endproperty
   a_stop_ptr: assert property (p_stop_ptr)
      else $error("Stop did not reset pointer");
   property p_no_cond_driving;
      @(posedge i_clk) disable iff (!rstn_q)
         o_sda_oe |-> (!start_det && !stop_det);
   endproperty
   a_no_cond_driving: assert property (p_no_cond_driving)
      else $error("Condition seen while driving");
   property p_wrap;
      @(posedge i_clk) disable iff (!rstn_q)
         (cnt_q == 24'hFFFFFF && cnt_d == 24'h000000 && clr_s && !clr_cmd)
         |=> (wrap_q != $past(wrap_q));
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("Wrap output did not toggle");
endmodule

// file: shared/eci_params.svh
// Constants for the event counter two-wire target interface.
// Included by the package and the eci_target module by bare name.
`ifndef ECI_PARAMS_SVH
`define ECI_PARAMS_SVH
`define ECI_TARGET_ADDR 7'h32
`define ECI_CNT_WIDTH 24
`define ECI_SCRATCH_WIDTH 21
`define ECI_CLEAR_PATTERN 3'h2
`define ECI_SCRATCH_RESET 21'h000000
`define ECI_CMD_RESET 3'h7
`define ECI_PTR_BIT 7
`define ECI_REG_BYTES 3'h3
`define ECI_IDLE_BYTE 8'hFF
`endif

// file: shared/eci_pkg.sv
// Types for the event counter two-wire target interface.
// Needs eci_params.svh on the include path.
package eci_pkg;
`include "eci_params.svh"
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_ADDR  = 6'h02,
      ST_WRITE = 6'h04,
      ST_WACK  = 6'h08,
      ST_READ  = 6'h10,
      ST_RACK  = 6'h20
   } eci_state_type;
endpackage

// file: verilog/eci_sync.sv
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes i_rstn already released synchronously by the top.
`timescale 1ns/100ps
module eci_sync (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Level in and out
   input wire logic i_async,
   output logic o_sync
);
   logic meta_q;
   logic sync_q;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end
   assign o_sync = sync_q;
endmodule

// file: sim/eci_bus_master.sv
// Two-wire bus controller model facing the counter target.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/100ps
module eci_bus_master (
   // Clock
   input wire logic i_clk,
   // Bus
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_oe
);
   // Bus clock stands high between frames
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end
   // Half of the 64 ns bus clock period
   task half();
      repeat (4) @(posedge i_clk);
      #1;
   endtask
   task bit_out(input logic b);
      o_sda_oe = ~b;
      half();
      o_scl = 1'b1;
      half();
      o_scl = 1'b0;
   endtask
   task bit_in(output logic b);
      o_sda_oe = 1'b0;
      half();
      o_scl = 1'b1;
      half();
      b = i_sda;
      o_scl = 1'b0;
   endtask
   // Works from idle and as a repeated start
   task start();
      o_sda_oe = 1'b0;
      half();
      o_scl = 1'b1;
      half();
      o_sda_oe = 1'b1;
      half();
      o_scl = 1'b0;
   endtask
   task stop();
      o_sda_oe = 1'b1;
      half();
      o_scl = 1'b1;
      half();
      o_sda_oe = 1'b0;
      half();
   endtask
   task wr_byte(input logic [7:0] d, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bit_out(d[i]);
      bit_in(a);
      ack = ~a;
   endtask
   task rd_byte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) bit_in(d[i]);
      bit_out(last);
   endtask
   // Data released for nine clocks frees a stuck target
   task recover();
      logic b;
      start();
      repeat (9) bit_in(b);
      stop();
   endtask
endmodule

// file: sim/testbench.sv
// Self-checking bench for the counter two-wire target.
// Assumes the controller model drives the bus clock and data pull-down.
`timescale 1ns/100ps
module testbench;
   import eci_pkg::*;
   typedef struct {logic [7:0] b3, b4, b5; logic clr;} eci_row_type;
   logic clk, rstn, count_in, clear_n, scl, m_oe, sda, oe, so, wrap;
   int n_oe = 0;
   int oe_mark;
   logic [23:0] cnt, exp_cnt;
   logic [20:0] scr;
   logic [2:0] cmd;
   logic [7:0] d;
   int n_mismatch, num_checks;
   eci_row_type rows [4] = '{'{8'hA5, 8'h3C, 8'hF7, 1'b0},
      '{8'h12, 8'h34, 8'h52, 1'b1}, '{8'hFF, 8'hFF, 8'hF8, 1'b0},
      '{8'h00, 8'h01, 8'h0B, 1'b0}};
   // Open-drain wire with pull-up
   assign sda = ~m_oe & (oe ? so : 1'b1);
   eci_target eci_target_inst (.i_clk(clk), .i_rstn(rstn), .i_scl(scl),
      .i_sda(sda), .o_sda(so), .o_sda_oe(oe), .i_count_in(count_in),
      .i_clear_n(clear_n), .o_wrap(wrap), .o_count_value_bits(cnt),
      .o_scratch_bits(scr), .o_counter_clear_command_bits(cmd));
   eci_bus_master eci_bus_master_inst (.i_clk(clk), .i_sda(sda),
      .o_scl(scl), .o_sda_oe(m_oe));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Cycles the target pulled data low; one writer only
   always @(posedge clk) if (oe === 1'b1) n_oe <= n_oe + 1;
   task report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input string nm, input logic [23:0] seen, input logic [23:0] ex);
      num_checks++;
      if (seen !== ex) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task pulse(input int n);
      repeat (n) begin
         count_in = 1'b1;
         tick(5);
         count_in = 1'b0;
         tick(5);
      end
   endtask
   task wr(input logic [7:0] v);
      logic ack;
      eci_bus_master_inst.wr_byte(v, ack);
      chk("ack", ack, 1'b1);
   endtask
   task rd_regs(input logic [23:0] ex);
      eci_bus_master_inst.start();
      wr(8'h65);
      for (int k = 0; k < 4; k++) begin
         eci_bus_master_inst.rd_byte(k == 3, d);
         chk("rd", d, k < 3 ? ex[23-8*k -: 8] : 8'hFF);
      end
      eci_bus_master_inst.stop();
   endtask
   task ptr(input logic [7:0] p);
      eci_bus_master_inst.start();
      wr(8'h64);
      wr(p);
   endtask
   initial begin
      rstn = 1'b0;
      count_in = 1'b0;
      clear_n = 1'b1;
      exp_cnt = 24'h000000;
      tick(3);
      rstn = 1'b1;
      tick(10);
      chk("cnt0", cnt, 24'h000000);
      chk("scr0", scr, 21'h000000);
      chk("cmd0", cmd, 3'h7);
      chk("oe0", oe, 1'b0);
      chk("wrap0", wrap, 1'b0);
      eci_bus_master_inst.recover();
      $display("done reset");
      foreach (rows[i]) begin
         pulse(3);
         exp_cnt = rows[i].clr ? 24'h000000 : exp_cnt + 24'h000003;
         ptr(8'h81);
         wr(rows[i].b3);
         wr(rows[i].b4);
         wr(rows[i].b5);
         eci_bus_master_inst.stop();
         tick(4);
         chk("scr", scr, {rows[i].b3, rows[i].b4, rows[i].b5[7:3]});
         chk("cmd", cmd, rows[i].b5[2:0]);
         chk("cnt", cnt, exp_cnt);
         ptr(8'h01);
         rd_regs({rows[i].b3, rows[i].b4, rows[i].b5});
         $display("done row %0d", i);
      end
      // Pulses begin only once the start is seen, else one still counts
      fork
         rd_regs(exp_cnt);
         begin
            tick(16);
            pulse(3);
         end
      join
      chk("frozen", cnt, exp_cnt);
      eci_bus_master_inst.start();
      wr(8'h65);
      count_in = 1'b1;
      eci_bus_master_inst.rd_byte(1'b1, d);
      eci_bus_master_inst.stop();
      exp_cnt = exp_cnt + 24'h000001;
      tick(6);
      chk("bump", cnt, exp_cnt);
      count_in = 1'b0;
      tick(5);
      $display("done freeze");
      oe_mark = n_oe;
      eci_bus_master_inst.start();
      eci_bus_master_inst.wr_byte(8'h66, d[0]);
      eci_bus_master_inst.stop();
      chk("foreign", {d[0], n_oe != oe_mark}, 2'b00);
      ptr(8'h01);
      eci_bus_master_inst.stop();
      rd_regs(exp_cnt);
      $display("done pointer");
      ptr(8'h81);
      wr(8'hC3);
      clear_n = 1'b0;
      tick(3);
      clear_n = 1'b1;
      wr(8'h5A);
      wr(8'h7F);
      eci_bus_master_inst.stop();
      tick(4);
      chk("clrpin", {scr, cmd, cnt}, {21'h186B4F, 3'h7, 24'h000000});
      exp_cnt = 24'h000000;
      eci_bus_master_inst.start();
      wr(8'h65);
      eci_bus_master_inst.recover();
      rd_regs(exp_cnt);
      $display("done recovery");
      report_and_stop();
   end
   initial begin
      repeat (90000) @(posedge clk);
      n_mismatch++;
      report_and_stop();
   end
endmodule
